//--- hdl/aspc_top.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_top import aspc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic convert_start_pin,
  // Sequence list loading
  input wire logic seq_wr_en,
  input wire logic [SEQ_AW-1:0] seq_wr_addr,
  input wire logic [CH_W-1:0] seq_wr_chan,
  input wire logic [SEQ_AW-1:0] seq_len_m1,
  // Converter core
  input wire logic conv_step,
  input wire logic conv_all_done,
  // Status
  output logic [3:0] scan_mode,
  output logic [CH_W-1:0] channel_select_field,
  output logic [CH_W-1:0] active_channel,
  output logic [15:0] analog_input_sel,
  output logic ext_clock_mode,
  output logic averaging_en,
  output logic [1:0] static_power_mode_bits,
  output logic auto_power_mode_hi,
  output logic auto_power_mode_lo,
  output logic bias_on,
  output logic core_on,
  output logic conv_valid,
  output logic conv_request
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] cs_sync, sclk_sync, din_sync, cnv_sync;
  logic cs_q, sclk_q, cnv_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync <= 2'h0;
      cnv_sync <= 2'h3;
      cs_q <= 1'h1;
      sclk_q <= 1'h0;
      cnv_q <= 1'h1;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      din_sync <= {din_sync[0], din};
      cnv_sync <= {cnv_sync[0], convert_start_pin};
      cs_q <= cs_sync[1];
      sclk_q <= sclk_sync[1];
      cnv_q <= cnv_sync[1];
    end
  end

  wire cs_fall = cs_q & ~cs_sync[1];
  wire cs_rise = ~cs_q & cs_sync[1];
  wire sclk_rise = ~sclk_q & sclk_sync[1];
  wire cnv_fall = cnv_q & ~cnv_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial word capture
  logic [WORD_W-1:0] shreg;
  logic [4:0] bit_cnt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shreg <= '0;
      bit_cnt <= 5'h0;
    end else if (cs_fall) begin
      bit_cnt <= 5'h0;
    end else if (!cs_sync[1] && sclk_rise) begin
      shreg <= {shreg[WORD_W-2:0], din_sync[1]};
      if (bit_cnt != 5'(WORD_W)) begin
        bit_cnt <= bit_cnt + 5'h1;
      end
    end
  end

  wire word_done = cs_rise && (bit_cnt == 5'(WORD_W));
  wire is_mode_wr = word_done && (shreg[SETUP_HI] == MODE_SEL);
  wire is_cfg_wr = word_done
    && (shreg[SETUP_HI:SETUP_LO] == CFG_SETUP);
  wire [3:0] wr_scan = shreg[SCAN_HI:SCAN_LO];
  wire scan_reserved = wr_scan > SCAN_SEQ;
  wire mode_take = is_mode_wr && !scan_reserved;
  wire sw_convert = is_mode_wr && !scan_reserved
    && shreg[SOFTWARE_CONVERT_BIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, kept across auto power down
  logic [1:0] pm_field;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_mode <= SCAN_RST;
      channel_select_field <= '0;
      pm_field <= PM_NORMAL;
      static_power_mode_bits <= SPM_ON;
    end else begin
      if (mode_take) begin
        scan_mode <= wr_scan;
        channel_select_field <= shreg[CHSEL_HI:CHSEL_LO];
        pm_field <= shreg[PM_HI:PM_LO];
      end
      if (is_cfg_wr) begin
        static_power_mode_bits <= shreg[SPM_HI:SPM_LO];
      end
    end
  end

  wire seq_mode = scan_mode == SCAN_SEQ;
  // Odd scan codes up to 7 are internal clock; 4,6,8,9 external
  wire ext_mode = seq_mode || (scan_mode == SCAN_STD_EXT)
    || (scan_mode[3] && !scan_mode[0])
    || (!scan_mode[3] && scan_mode[2] && !scan_mode[0]);

  ////////////////////////////////////////////////////////////////////////////
  // Long-sequence channel list
  logic [SEQ_AW-1:0] seq_ptr;
  logic [CH_W-1:0] seq_chan;

  aspc_seq_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(seq_wr_en),
    .wr_addr(seq_wr_addr),
    .wr_data(seq_wr_chan),
    .rd_addr(seq_ptr),
    .rd_data(seq_chan)
  );

  always_ff @(posedge sys_clk) begin
    if (rst || mode_take || !seq_mode) begin
      seq_ptr <= '0;
    end else if (conv_step) begin
      seq_ptr <= (seq_ptr == seq_len_m1) ? '0 : seq_ptr + 8'h1;
    end
  end

  wire [CH_W-1:0] next_active = seq_mode ? seq_chan
    : channel_select_field;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode
  logic [15:0] next_ain;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dec
      assign next_ain[gi] = next_active == CH_W'(gi);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power state
  aspc_pwr_e pstate, next_pstate;
  logic [1:0] wake_cnt;
  logic armed;

  wire auto_pm = (pm_field == PM_SHDN) || (pm_field == PM_STBY);
  wire ext_sleep = ext_mode && auto_pm && armed && cs_rise;
  wire int_sleep = !ext_mode && auto_pm && conv_all_done;
  wire ext_wake = ext_mode && cs_fall;
  wire int_wake = !ext_mode && (cnv_fall || sw_convert);
  wire static_down = static_power_mode_bits != SPM_ON;

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      ASPC_ON:
        if (ext_sleep || int_sleep) next_pstate = ASPC_DOWN;
      ASPC_DOWN:
        if (!auto_pm) next_pstate = ASPC_ON;
        else if (ext_wake || int_wake) next_pstate = ASPC_WAKE;
      ASPC_WAKE:
        if (wake_cnt == WAKE_CNT) next_pstate = ASPC_ON;
      default: next_pstate = ASPC_ON;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pstate <= ASPC_ON;
      wake_cnt <= 2'h0;
      armed <= 1'h0;
    end else begin
      pstate <= next_pstate;
      wake_cnt <= (pstate == ASPC_WAKE) ? wake_cnt + 2'h1 : 2'h1;
      // Sleep at the frame after the one that set auto mode
      if (!auto_pm) armed <= 1'h0;
      else if (cs_fall) armed <= 1'h1;
    end
  end

  aspc_pwr_s next_pwr;
  always_comb begin
    next_pwr.core_on = !static_down && (pstate != ASPC_DOWN);
    next_pwr.bias_on = (static_power_mode_bits == SPM_PART)
      || (!static_down && (pstate != ASPC_DOWN
      || pm_field == PM_STBY));
    next_pwr.conv_valid = next_pwr.core_on && pstate == ASPC_ON;
    if (static_power_mode_bits == SPM_FULL) begin
      next_pwr.bias_on = 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_channel <= '0;
      analog_input_sel <= 16'h0001;
      ext_clock_mode <= 1'h0;
      averaging_en <= 1'h0;
      auto_power_mode_hi <= 1'h0;
      auto_power_mode_lo <= 1'h0;
      bias_on <= 1'h1;
      core_on <= 1'h1;
      conv_valid <= 1'h1;
      conv_request <= 1'h0;
    end else begin
      active_channel <= next_active;
      analog_input_sel <= next_ain;
      ext_clock_mode <= ext_mode;
      averaging_en <= !ext_mode;
      auto_power_mode_hi <= pm_field[1];
      auto_power_mode_lo <= pm_field[0];
      bias_on <= next_pwr.bias_on;
      core_on <= next_pwr.core_on;
      conv_valid <= next_pwr.conv_valid;
      conv_request <= !ext_mode && (cnv_fall || sw_convert);
    end
  end
endmodule
`default_nettype wire

//--- hdl/aspc_pkg.sv
package aspc_pkg;
  // Serial word layout
  localparam int WORD_W = 16;
  localparam int SCAN_HI = 14;
  localparam int SCAN_LO = 11;
  localparam int CHSEL_HI = 10;
  localparam int CHSEL_LO = 7;
  localparam int PM_HI = 3;
  localparam int PM_LO = 2;
  localparam int SOFTWARE_CONVERT_BIT_BIT = 1;
  localparam int SPM_HI = 1;
  localparam int SPM_LO = 0;
  localparam int SETUP_HI = 15;
  localparam int SETUP_LO = 11;
  localparam logic [4:0] CFG_SETUP = 5'h10;
  localparam logic MODE_SEL = 1'h0;

  // Scan codes
  localparam logic [3:0] SCAN_STD_EXT = 4'h4;
  localparam logic [3:0] SCAN_SEQ = 4'h9;
  localparam logic [3:0] SCAN_RST = 4'h1;

  // Power codes
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_SHDN = 2'h1;
  localparam logic [1:0] PM_STBY = 2'h2;
  localparam logic [1:0] SPM_ON = 2'h0;
  localparam logic [1:0] SPM_FULL = 2'h1;
  localparam logic [1:0] SPM_PART = 2'h2;

  // Sequence list
  localparam int SEQ_DEPTH = 256;
  localparam int SEQ_AW = 8;
  localparam int CH_W = 4;

  // Wake delay
  localparam int WAKE_CYC = 2;
  localparam logic [1:0] WAKE_CNT = 2'(WAKE_CYC);

  typedef enum logic [1:0] {
    ASPC_ON = 2'b00,
    ASPC_DOWN = 2'b01,
    ASPC_WAKE = 2'b11
  } aspc_pwr_e;

  typedef struct packed {
    logic bias_on;
    logic core_on;
    logic conv_valid;
  } aspc_pwr_s;
endpackage

//--- hdl/aspc_seq_mem.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_seq_mem import aspc_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Write side
  input wire logic wr_en,
  input wire logic [SEQ_AW-1:0] wr_addr,
  input wire logic [CH_W-1:0] wr_data,
  // Read side
  input wire logic [SEQ_AW-1:0] rd_addr,
  output logic [CH_W-1:0] rd_data
);
  logic [CH_W-1:0] mem [SEQ_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

//--- bench/aspc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_top_chk import aspc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Status
  input wire logic [3:0] scan_mode,
  input wire logic [CH_W-1:0] active_channel,
  input wire logic [15:0] analog_input_sel,
  input wire logic ext_clock_mode,
  input wire logic averaging_en,
  input wire logic [1:0] static_power_mode_bits,
  input wire logic auto_power_mode_hi,
  input wire logic auto_power_mode_lo,
  input wire logic bias_on,
  input wire logic core_on,
  input wire logic conv_valid,
  input wire logic conv_request
);
  logic [1:0] pm;
  assign pm = {auto_power_mode_hi, auto_power_mode_lo};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_sel_onehot: assert property (
    $stable(active_channel) [*2] |->
    analog_input_sel == (16'h1 << active_channel)) else $error("Bad sel");
  chk_resv_code: assert property (
    scan_mode < 4'ha) else $error("Reserved scan code taken");
  chk_seq_ext: assert property (
    scan_mode == SCAN_SEQ [*2] |-> ext_clock_mode && !averaging_en)
    else $error("Sequence mode clocking");
  chk_full_off: assert property (
    static_power_mode_bits == SPM_FULL [*3] |-> !bias_on && !core_on)
    else $error("Full shutdown powered");
  chk_part_bias: assert property (
    static_power_mode_bits == SPM_PART [*3] |-> bias_on && !core_on)
    else $error("Partial shutdown power");
  chk_normal_on: assert property (
    (pm == PM_NORMAL && static_power_mode_bits == SPM_ON) [*3] |->
    core_on && bias_on) else $error("Normal mode not powered");
  chk_valid_power: assert property (
    conv_valid |-> core_on && bias_on) else $error("Valid while off");
  chk_wake_wait: assert property (
    $rose(core_on) && pm != PM_NORMAL |->
    !conv_valid [*2] ##[1:3] conv_valid) else $error("Wake delay");
  chk_req_pulse: assert property (
    conv_request |=> !conv_request) else $error("Request too long");
endmodule
bind aspc_top aspc_top_chk aspc_top_chk_i (.*);
`default_nettype wire

//--- bench/aspc_host.sv
`timescale 1ns/1ps
`default_nettype none
module aspc_host (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // One 16-bit word, MSB first, sclk 80 ns and idle low between frames
  task automatic send(input logic [15:0] w);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din <= w[i];
      repeat (10) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (10) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (10) @(posedge sys_clk);
    cs_n <= 1'b1;
    din <= ~w[0];
    repeat (12) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import aspc_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n;
  logic sclk;
  logic din;
  logic convert_start_pin = 1'b1;
  logic seq_wr_en = 1'b0;
  logic [SEQ_AW-1:0] seq_wr_addr = 8'h0;
  logic [CH_W-1:0] seq_wr_chan = 4'h0;
  logic [SEQ_AW-1:0] seq_len_m1 = 8'h3;
  logic conv_step = 1'b0;
  logic conv_all_done = 1'b0;
  logic [3:0] scan_mode;
  logic [CH_W-1:0] channel_select_field;
  logic [CH_W-1:0] active_channel;
  logic [15:0] analog_input_sel;
  logic ext_clock_mode;
  logic averaging_en;
  logic [1:0] static_power_mode_bits;
  logic auto_power_mode_hi;
  logic auto_power_mode_lo;
  logic bias_on;
  logic core_on;
  logic conv_valid;
  logic conv_request;
  logic [3:0] lst [4] = '{4'h7, 4'h2, 4'hf, 4'h0};
  logic [1:0] sp [3] = '{SPM_FULL, SPM_PART, SPM_ON};
  int bad_count = 0;
  int check_count = 0;
  int req_cnt = 0;
  aspc_top aspc_top_i (.*);
  aspc_host aspc_host_i (.*);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_request === 1'b1) req_cnt <= req_cnt + 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] mw(input logic [3:0] s, input logic [3:0] c,
                                     input logic [1:0] p, input logic sw);
    return {MODE_SEL, s, c, 3'h0, p, sw, 1'b0};
  endfunction
  task automatic t_chan;
    for (int i = 0; i < 16; i++) begin
      aspc_host_i.send(mw(SCAN_STD_EXT, 4'(i), PM_NORMAL, 1'b0));
      chk("chan", 16'(i), {12'h0, channel_select_field});
      chk("sel", 16'h1 << i, analog_input_sel);
    end
    $display("t_chan done");
  endtask
  task automatic t_resv;
    aspc_host_i.send(mw(SCAN_STD_EXT, 4'h3, PM_NORMAL, 1'b0));
    for (int c = 10; c < 16; c++) begin
      aspc_host_i.send(mw(4'(c), 4'h9, PM_SHDN, 1'b1));
      chk("resv", {6'h0, SCAN_STD_EXT, 4'h3, PM_NORMAL}, {6'h0, scan_mode,
          channel_select_field, auto_power_mode_hi, auto_power_mode_lo});
    end
    $display("t_resv done");
  endtask
  task automatic t_seq;
    for (int i = 0; i < 4; i++) begin
      seq_wr_addr <= 8'(i);
      seq_wr_chan <= lst[i];
      seq_wr_en <= 1'b1;
      cyc(1);
    end
    seq_wr_en <= 1'b0;
    aspc_host_i.send(mw(SCAN_SEQ, 4'h0, PM_NORMAL, 1'b0));
    chk("seqmode", {10'h0, SCAN_SEQ, 2'b10},
        {10'h0, scan_mode, ext_clock_mode, averaging_en});
    for (int k = 0; k < 6; k++) begin
      chk("seqch", {12'h0, lst[k % 4]}, {12'h0, active_channel});
      conv_step <= 1'b1;
      cyc(1);
      conv_step <= 1'b0;
      cyc(4);
    end
    $display("t_seq done");
  endtask
  task automatic t_static;
    for (int i = 0; i < 3; i++) begin
      aspc_host_i.send({CFG_SETUP, 9'h0, sp[i]});
      chk("stat", {12'h0, sp[i], sp[i] != SPM_FULL, sp[i] == SPM_ON},
          {12'h0, static_power_mode_bits, bias_on, core_on});
    end
    $display("t_static done");
  endtask
  task automatic t_auto;
    for (int p = 1; p < 3; p++) begin
      aspc_host_i.send(mw(SCAN_STD_EXT, 4'h3, 2'(p), 1'b0));
      chk("armed", 16'h1, {15'h0, core_on});
      aspc_host_i.send(mw(SCAN_STD_EXT, 4'h3, 2'(p), 1'b0));
      chk("down", {13'h0, p == 2, 2'b00},
          {13'h0, bias_on, core_on, conv_valid});
      fork
        aspc_host_i.send(mw(SCAN_STD_EXT, 4'h3, PM_NORMAL, 1'b0));
        begin
          cyc(60);
          chk("wake", 16'h1f, {9'h0, channel_select_field, bias_on, core_on,
              conv_valid});
        end
      join
      chk("normal", 16'h7, {13'h0, bias_on, core_on, conv_valid});
    end
    $display("t_auto done");
  endtask
  task automatic done_pulse;
    conv_all_done <= 1'b1;
    cyc(1);
    conv_all_done <= 1'b0;
    cyc(8);
    chk("isleep", 16'h0, {15'h0, core_on});
  endtask
  task automatic t_int;
    int n;
    aspc_host_i.send(mw(4'h3, 4'h1, PM_SHDN, 1'b0));
    done_pulse();
    n = req_cnt;
    convert_start_pin <= 1'b0;
    cyc(12);
    convert_start_pin <= 1'b1;
    chk("cnv", 16'(n + 1), 16'(req_cnt));
    chk("cnvwake", 16'h1, {15'h0, core_on});
    done_pulse();
    aspc_host_i.send(mw(4'h3, 4'h1, PM_SHDN, 1'b1));
    chk("software_convert_bit", 16'(n + 2), 16'(req_cnt));
    chk("swwake", 16'h1, {15'h0, core_on});
    $display("t_int done");
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    t_chan();
    t_resv();
    t_seq();
    t_static();
    t_auto();
    t_int();
    final_report();
  end
  initial begin
    cyc(40000);
    bad_count++;
    $display("Error watchdog expected done seen timeout");
    final_report();
  end
endmodule
`default_nettype wire
